/* File: pin_cfg_pkg.sv */
// Constants, register map and carriers for the seven-pin configuration bank.
// Assumes a 10 MHz system clock and an 8-bit register port with byte offsets.
//
// Functional notes
// - Pin one output source: value or first LED
// - Pin three source: value, second LED, PWM
// - Debounce select 0: 91.5 us, 30.5 us ticks
// - Debounce select 1: 150 ms, 50 ms ticks
// - Bit 3 enables pulldown, resets to one
// - Bit 2 direction: 0 input, 1 output
// - Bit 1 reads pad level, resets one
// - Bit 0 is the driven output value
// - Sleep bit forces pins 2,6,7 low outputs
// - Power-down reset clears pulldown on sequence pins
// - Power-down reset makes sequence pins outputs
// - General reset restores all configuration registers
// - Debounced edges set W1C rise/fall flags
// - Masked flags still set, interrupt stays low
package pin_cfg_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] PIN_OFS [1:7] = '{8'h61, 8'h62, 8'h63, 8'h64, 8'h65, 8'h66, 8'h67};
  localparam logic [7:0] RISE_STS_OFS = 8'h70;
  localparam logic [7:0] FALL_STS_OFS = 8'h71;
  localparam logic [7:0] RISE_MSK_OFS = 8'h72;
  localparam logic [7:0] FALL_MSK_OFS = 8'h73;

  // Writable bits per pin; reserved bits read back zero, the level bit reads the pad
  localparam logic [7:0] PIN_WMASK [1:7] = '{8'h3d, 8'h9d, 8'h7d, 8'h1d, 8'h1d, 8'h9d, 8'h9d};
  localparam logic [7:1] SEQ_PINS = 7'h62;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int BIT_SET   = 0;
  localparam int BIT_LEVEL = 1;
  localparam int BIT_DIR   = 2;
  localparam int BIT_PDEN  = 3;
  localparam int BIT_DEB   = 4;
  localparam int BIT_SRC   = 5;
  localparam int BIT_SLEEP = 7;
  localparam logic [7:0] PIN_CFG_RST  = 8'h08;
  localparam logic [7:0] SEQ_CLR_MASK = 8'h09;
  localparam logic [7:0] SEQ_SET_MASK = 8'h04;
  localparam logic [7:1] LEVEL_RST    = 7'h7f;
  localparam logic [7:1] MSK_RST      = 7'h7f;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int FAST_TICK_NS  = 30500;
  localparam int FAST_DEB_NS   = 91500;
  localparam int SLOW_TICK_MS  = 50;
  localparam int SLOW_DEB_MS   = 150;
  localparam int FAST_TICK_CYC = FAST_TICK_NS / CLK_PERIOD_NS;
  localparam int SLOW_TICK_CYC = SLOW_TICK_MS * 1000000 / CLK_PERIOD_NS;
  localparam int DEB_SAMPLES   = FAST_DEB_NS / FAST_TICK_NS;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wrData;
    logic       wrStb;
    logic       rdStb;
  } bus_req_t;

  typedef struct packed {
    logic firstLed;
    logic secondLed;
    logic pwm;
  } alt_src_t;

endpackage : pin_cfg_pkg

/* File: pin_config_bank.sv */
// Seven-pin configuration bank: per-pin config bytes, debounce, edge flags, interrupt.
// Assumes pad inputs and alternate sources are synchronous to mclk.
`timescale 1ns/100ps
`default_nettype none

module pin_config_bank #(
  parameter int SLOW_TICK_CYCLES = pin_cfg_pkg::SLOW_TICK_CYC
) (
  // Clock and reset
  input  wire logic                  mclk,
  input  wire logic                  nrst,
  // Register port
  input  wire pin_cfg_pkg::bus_req_t busReq,
  output var  logic [7:0]            rdData_q,
  // Power state
  input  wire logic                  powerDownReset,
  input  wire logic                  sleepMode,
  // Alternate output sources
  input  wire pin_cfg_pkg::alt_src_t altSrc,
  // Pads
  input  wire logic [7:1]            padIn,
  output var  logic [7:1]            padOut_q,
  output var  logic [7:1]            padOe_q,
  output var  logic [7:1]            pulldownEn_q,
  // Interrupt
  output var  logic                  interruptLine_q
);
  import pin_cfg_pkg::*;

  // ----------------------------------------------------------------
  // Timebases
  // ----------------------------------------------------------------
  logic [8:0]  fastCnt_q;
  logic [18:0] slowCnt_q;
  wire         fastTick = (fastCnt_q == 9'(FAST_TICK_CYC - 1));
  wire         slowTick = (slowCnt_q == 19'(SLOW_TICK_CYCLES - 1));

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      fastCnt_q <= 9'h000;
      slowCnt_q <= 19'h00000;
    end else begin
      fastCnt_q <= fastTick ? 9'h000 : fastCnt_q + 9'h001;
      slowCnt_q <= slowTick ? 19'h00000 : slowCnt_q + 19'h00001;
    end
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0] cfg_q [1:7];
  logic [7:0] cfg_d [1:7];
  logic [1:0] debCnt_q [1:7];
  logic [7:1] padLevel_q;
  logic [7:1] stable_q;
  logic [7:1] riseEv;
  logic [7:1] fallEv;
  logic [7:1] riseSts_q;
  logic [7:1] fallSts_q;
  logic [7:1] riseMsk_q;
  logic [7:1] fallMsk_q;
  logic [7:1] padOut_d;
  logic [7:1] padOe_d;
  logic [7:1] pulldownEn_d;
  logic [7:0] rdMux;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  function automatic logic hitWr(input bus_req_t r, input logic [7:0] ofs);
    hitWr = r.wrStb && (r.addr == ofs);
  endfunction : hitWr

  wire [7:1] riseClr = hitWr(busReq, RISE_STS_OFS) ? busReq.wrData[7:1] : 7'h00;
  wire [7:1] fallClr = hitWr(busReq, FALL_STS_OFS) ? busReq.wrData[7:1] : 7'h00;
  wire [7:1] riseSts_d = (riseSts_q & ~riseClr) | riseEv;
  wire [7:1] fallSts_d = (fallSts_q & ~fallClr) | fallEv;
  wire [7:1] riseMsk_d = hitWr(busReq, RISE_MSK_OFS) ? busReq.wrData[7:1] : riseMsk_q;
  wire [7:1] fallMsk_d = hitWr(busReq, FALL_MSK_OFS) ? busReq.wrData[7:1] : fallMsk_q;
  // Masked flags still latch; only the line is gated
  wire       irq_d = |((riseSts_q & ~riseMsk_q) | (fallSts_q & ~fallMsk_q));

  // ----------------------------------------------------------------
  // Per-pin logic
  // ----------------------------------------------------------------
  genvar i;
  generate
    for (i = 1; i <= 7; i++) begin : g_pin
      wire       wrHit   = hitWr(busReq, PIN_OFS[i]);
      wire       seqOff  = powerDownReset && SEQ_PINS[i];
      wire [7:0] wrVal   = busReq.wrData & PIN_WMASK[i];
      wire       tick    = cfg_q[i][BIT_DEB] ? slowTick : fastTick;
      wire       differs = padLevel_q[i] != stable_q[i];
      wire       settle  = tick && differs && (debCnt_q[i] == 2'(DEB_SAMPLES - 1));
      wire       sleepLow;
      logic      srcVal;

      // Power-down reset wins over a same-cycle write
      assign cfg_d[i] = seqOff ? ((cfg_q[i] & ~SEQ_CLR_MASK) | SEQ_SET_MASK)
                      : wrHit ? wrVal : cfg_q[i];
      assign riseEv[i] = settle && padLevel_q[i];
      assign fallEv[i] = settle && !padLevel_q[i];

      if (i == 1) begin : g_src1
        assign srcVal = cfg_q[i][BIT_SRC] ? altSrc.firstLed : cfg_q[i][BIT_SET];
      end else if (i == 3) begin : g_src3
        always_comb begin
          case (cfg_q[i][BIT_SRC+1:BIT_SRC])
            2'h1:    srcVal = altSrc.secondLed;
            2'h2:    srcVal = altSrc.pwm;
            default: srcVal = cfg_q[i][BIT_SET];
          endcase
        end
      end else begin : g_src
        assign srcVal = cfg_q[i][BIT_SET];
      end

      if (SEQ_PINS[i]) begin : g_sleep
        assign sleepLow = sleepMode && cfg_q[i][BIT_SLEEP];
      end else begin : g_nosleep
        assign sleepLow = 1'b0;
      end

      assign padOe_d[i]      = cfg_q[i][BIT_DIR] || sleepLow;
      assign padOut_d[i]     = sleepLow ? 1'b0 : srcVal;
      assign pulldownEn_d[i] = cfg_q[i][BIT_PDEN];

      always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
          cfg_q[i]    <= PIN_CFG_RST;
          debCnt_q[i] <= 2'h0;
          stable_q[i] <= 1'b1;
        end else begin
          cfg_q[i] <= cfg_d[i];
          // Three agreeing samples are needed before the level is accepted
          if (tick) begin
            debCnt_q[i] <= (differs && !settle) ? debCnt_q[i] + 2'h1 : 2'h0;
            if (settle) begin
              stable_q[i] <= padLevel_q[i];
            end
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  always_comb begin
    rdMux = 8'h00;
    for (int k = 1; k <= 7; k++) begin
      if (busReq.addr == PIN_OFS[k]) begin
        rdMux = cfg_q[k] | {6'h00, padLevel_q[k], 1'b0};
      end
    end
    case (busReq.addr)
      RISE_STS_OFS: rdMux = {riseSts_q, 1'b0};
      FALL_STS_OFS: rdMux = {fallSts_q, 1'b0};
      RISE_MSK_OFS: rdMux = {riseMsk_q, 1'b0};
      FALL_MSK_OFS: rdMux = {fallMsk_q, 1'b0};
      default:      rdMux = rdMux;
    endcase
  end

  // ----------------------------------------------------------------
  // Shared registers and outputs
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      padLevel_q      <= LEVEL_RST;
      riseSts_q       <= 7'h00;
      fallSts_q       <= 7'h00;
      riseMsk_q       <= MSK_RST;
      fallMsk_q       <= MSK_RST;
      rdData_q        <= 8'h00;
      padOut_q        <= 7'h00;
      padOe_q         <= 7'h00;
      pulldownEn_q    <= 7'h7f;
      interruptLine_q <= 1'b0;
    end else begin
      padLevel_q      <= padIn;
      riseSts_q       <= riseSts_d;
      fallSts_q       <= fallSts_d;
      riseMsk_q       <= riseMsk_d;
      fallMsk_q       <= fallMsk_d;
      rdData_q        <= busReq.rdStb ? rdMux : 8'h00;
      padOut_q        <= padOut_d;
      padOe_q         <= padOe_d;
      pulldownEn_q    <= pulldownEn_d;
      interruptLine_q <= irq_d;
    end
  end

endmodule : pin_config_bank

`default_nettype wire

/* File: pin_config_bank_properties.sv */
// Checker bound to the ports of the pin configuration bank.
// Assumes one clock, mclk, and the asynchronous active-low reset nrst.
`timescale 1ns/100ps
`default_nettype none
module pin_config_bank_properties #(parameter int SLOW_TICK_CYCLES = 20) (
  // Clock, reset, register port
  input wire logic                  mclk,
  input wire logic                  nrst,
  input wire pin_cfg_pkg::bus_req_t busReq,
  input wire logic [7:0]            rdData_q,
  // Power state and sources
  input wire logic                  powerDownReset,
  input wire logic                  sleepMode,
  input wire pin_cfg_pkg::alt_src_t altSrc,
  // Pads and interrupt
  input wire logic [7:1]            padIn,
  input wire logic [7:1]            padOut_q,
  input wire logic [7:1]            padOe_q,
  input wire logic [7:1]            pulldownEn_q,
  input wire logic                  interruptLine_q
);
  import pin_cfg_pkg::*;
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  wire logic       wrS  = busReq.wrStb;
  wire logic [7:0] adr  = busReq.addr;
  wire logic [7:0] wdat = busReq.wrData;
  wire logic       maskWr = wrS && adr[7:1] == 7'h39 && wdat[7:1] != 7'h7f;
  logic            maskOpen_q;
  logic            sleep6_q;
  // Shadow only what the pads cannot show: an opened mask and the pin six sleep bit
  always_ff @(posedge mclk or negedge nrst)
    if (!nrst) {maskOpen_q, sleep6_q} <= 2'b00;
    else {maskOpen_q, sleep6_q} <= {maskOpen_q | maskWr, wrS && adr == 8'h66 ? wdat[7] : sleep6_q};
  a_reset_pads: assert property ($rose(nrst) |-> pulldownEn_q == 7'h7f && padOe_q == 7'h00)
    else $error("pads wrong after reset");
  a_pdr_seq: assert property (powerDownReset ##1 !wrS |=> (padOe_q & 7'h62) == 7'h62 &&
    (pulldownEn_q & 7'h62) == 7'h00 && (padOut_q & 7'h62) == 7'h00) else $error("seq pins wrong");
  a_pin4_drive: assert property (wrS && adr == 8'h64 && wdat[2] ##1 !wrS |=> padOe_q[4] &&
    padOut_q[4] == $past(wdat[0], 2) && pulldownEn_q[4] == $past(wdat[3], 2)) else $error("pin4");
  a_pin1_led: assert property (wrS && adr == 8'h61 && wdat[5] && wdat[2] ##1 !wrS |=>
    padOut_q[1] == $past(altSrc.firstLed)) else $error("pin1 source wrong");
  a_pin3_src: assert property (wrS && adr == 8'h63 && wdat[2] ##1 !wrS |=> padOut_q[3] ==
    ($past(wdat[6:5], 2) == 2'b01 ? $past(altSrc.secondLed) : $past(wdat[6:5], 2) == 2'b10 ?
    $past(altSrc.pwm) : $past(wdat[0], 2))) else $error("pin3 source wrong");
  a_sleep_low: assert property (sleep6_q && sleepMode && !wrS |=> padOe_q[6] && !padOut_q[6])
    else $error("pin6 not low in sleep");
  a_mask_quiet: assert property (!maskOpen_q |-> !interruptLine_q)
    else $error("interrupt while masked");
  a_clear_fall: assert property ($fell(interruptLine_q) |-> $past(wrS, 2))
    else $error("interrupt fell without write");
  a_level_read: assert property (busReq.rdStb && adr == 8'h64 |=> rdData_q[1] ==
    $past(padIn[4], 2) && rdData_q[7:5] == 3'h0) else $error("pin4 read wrong");
endmodule : pin_config_bank_properties
bind pin_config_bank pin_config_bank_properties #(.SLOW_TICK_CYCLES(SLOW_TICK_CYCLES)) u_props (
  .mclk, .nrst, .busReq, .rdData_q, .powerDownReset, .sleepMode, .altSrc, .padIn, .padOut_q,
  .padOe_q, .pulldownEn_q, .interruptLine_q);
`default_nettype wire

/* File: pad_model.sv */
// Pad model: the level each pad shows to the bank.
// Assumes the bench drives every pad that the bank leaves as input.
`timescale 1ns/100ps
`default_nettype none
module pad_model (
  // Bank side
  input  wire logic [7:1] padOut,
  input  wire logic [7:1] padOe,
  // Bench side
  input  wire logic [7:1] extVal,
  output var  logic [7:1] padIn
);
  // An output pin reads back its own drive, so level reads follow the bank
  always_comb padIn = (padOe & padOut) | (~padOe & extVal);
endmodule : pad_model
`default_nettype wire

/* File: pin_config_bank_tb.sv */
// Bench for the pin configuration bank: register tasks and scenarios.
// Assumes the pad model closes the loop from pad outputs to pad inputs.
`timescale 1ns/100ps
`default_nettype none
module pin_config_bank_tb;
  import pin_cfg_pkg::*;
  logic       mclk = 1'b0;
  logic       nrst = 1'b0;
  logic       pdr = 1'b0;
  logic       slp = 1'b0;
  bus_req_t   busReq = '0;
  alt_src_t   altSrc = '0;
  logic [7:1] extVal = 7'h7f;
  logic [7:1] padIn, padOut, padOe, pdEn;
  logic [7:0] rdData;
  logic       irq;
  int         n_mismatch = 0;
  int         num_checks = 0;
  always #50 mclk = ~mclk;
  pin_config_bank #(.SLOW_TICK_CYCLES(20)) u_dut (.mclk, .nrst, .busReq, .rdData_q(rdData),
    .powerDownReset(pdr), .sleepMode(slp), .altSrc, .padIn, .padOut_q(padOut),
    .padOe_q(padOe), .pulldownEn_q(pdEn), .interruptLine_q(irq));
  pad_model u_pads (.padOut, .padOe, .extVal, .padIn);
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : cyc
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk) busReq <= '{a, d, 1'b1, 1'b0};
    @(posedge mclk) busReq.wrStb <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge mclk) busReq <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge mclk) busReq.rdStb <= 1'b0;
    #1 chk(rdData, exp);
  endtask : rd
  task automatic t_drive;
    rd(8'h64, 8'h0a);
    rd(8'h73, 8'hfe);
    wr(8'h64, 8'h05);
    cyc(1);
    chk({5'h0, padOe[4], padOut[4], pdEn[4]}, 8'h06);
    wr(8'h64, 8'hff);
    rd(8'h64, 8'h1f);
    $display("t_drive done");
  endtask : t_drive
  task automatic t_alt;
    @(posedge mclk) altSrc <= '{1'b1, 1'b0, 1'b0};
    wr(8'h61, 8'h24);
    cyc(1);
    chk({7'h0, padOut[1]}, 8'h01);
    for (int p = 0; p < 2; p++) for (int c = 0; c < 4; c++) begin
      @(posedge mclk) altSrc <= '{1'b0, p[0], ~p[0]};
      wr(8'h63, {1'b0, c[1:0], 5'h04});
      cyc(1);
      chk({7'h0, padOut[3]}, {7'h0, c == 1 ? p[0] : c == 2 ? ~p[0] : 1'b0});
    end
    $display("t_alt done");
  endtask : t_alt
  task automatic t_pdr;
    wr(8'h62, 8'h09);
    @(posedge mclk) pdr <= 1'b1;
    @(posedge mclk) pdr <= 1'b0;
    cyc(1);
    chk({5'h0, padOe[2], padOut[2], pdEn[2]}, 8'h04);
    rd(8'h62, 8'h04);
    $display("t_pdr done");
  endtask : t_pdr
  task automatic t_sleep;
    wr(8'h66, 8'h80);
    cyc(1);
    chk({7'h0, padOe[6]}, 8'h00);
    @(posedge mclk) slp <= 1'b1;
    cyc(2);
    chk({6'h0, padOe[6], padOut[6]}, 8'h02);
    @(posedge mclk) slp <= 1'b0;
    $display("t_sleep done");
  endtask : t_sleep
  task automatic t_edges;
    // Earlier scenarios leave pins 1, 2, 3 and 7 driven low; let those edges settle, then clear
    cyc(1000);
    wr(8'h70, 8'hfe);
    wr(8'h71, 8'hfe);
    wr(8'h72, 8'hdf);
    @(posedge mclk) extVal[5] <= 1'b0;
    cyc(500);
    rd(8'h71, 8'h00);
    cyc(800);
    rd(8'h71, 8'h20);
    chk({7'h0, irq}, 8'h00);
    @(posedge mclk) extVal[5] <= 1'b1;
    cyc(1300);
    chk({7'h0, irq}, 8'h01);
    wr(8'h70, 8'h20);
    wr(8'h71, 8'h20);
    cyc(2);
    chk({7'h0, irq}, 8'h00);
    rd(8'h70, 8'h00);
    wr(8'h65, 8'h18);
    @(posedge mclk) extVal[5] <= 1'b0;
    cyc(30);
    rd(8'h71, 8'h00);
    cyc(60);
    rd(8'h71, 8'h20);
    $display("t_edges done");
  endtask : t_edges
  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : final_report
  initial begin
    repeat (3) @(posedge mclk);
    nrst <= 1'b1;
    t_drive;
    t_alt;
    t_pdr;
    t_sleep;
    t_edges;
    final_report;
  end
  // About 3800 cycles are needed; a hang is cut off well past that
  initial begin
    #2000000;
    n_mismatch++;
    final_report;
  end
endmodule : pin_config_bank_tb
`default_nettype wire
